// >>> dv/cdrf_core_model.sv
// Purpose: Behavioural core decoder and datapath driving the register set.
// Assumes: The bench calls one task at a time.
// Notes: Strobes last one cycle and change just after a rising edge.
`timescale 1ns/1ps
module cdrf_core_model
	import cdrf_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register strobes
	output logic ldEn,
	output cdrf_ldsel_t ldSel,
	output logic [15:0] ldData,
	output logic ptrStep,
	output logic aluGo,
	output cdrf_aluop_t aluOp,
	output logic aluByte,
	output logic stopWake,
	// Address, interrupt and programmer side
	output logic [15:0] memAddr,
	output logic irqReq,
	output logic [1:0] irqLevel,
	output logic serReadReq,
	output logic [7:0] protByte
);
	initial begin
		ldEn = 1'b0;
		ldSel = CDRF_LD_IPTR;
		ldData = 16'h0000;
		ptrStep = 1'b0;
		aluGo = 1'b0;
		aluOp = CDRF_OP_ADD;
		aluByte = 1'b0;
		stopWake = 1'b0;
		memAddr = 16'h0000;
		irqReq = 1'b0;
		irqLevel = 2'h0;
		serReadReq = 1'b0;
		protByte = 8'hFF;
	end
	// ====================
	// Operations
	// Load data is inverted once used, so a late sample cannot pass by luck.
	task automatic load(input cdrf_ldsel_t s, input logic [15:0] d);
		@(posedge clk);
		ldEn <= 1'b1;
		ldSel <= s;
		ldData <= d;
		@(posedge clk);
		ldEn <= 1'b0;
		ldData <= ~d;
	endtask : load
	task automatic alu(input cdrf_aluop_t o, input logic b);
		@(posedge clk);
		aluGo <= 1'b1;
		aluOp <= o;
		aluByte <= b;
		@(posedge clk);
		aluGo <= 1'b0;
	endtask : alu
	task automatic pulse(input logic wake);
		@(posedge clk);
		ptrStep <= !wake;
		stopWake <= wake;
		@(posedge clk);
		ptrStep <= 1'b0;
		stopWake <= 1'b0;
	endtask : pulse
	task automatic side(input logic [15:0] a, input logic r, input logic [1:0] l,
		input logic s, input logic [7:0] p);
		@(posedge clk);
		memAddr <= a;
		irqReq <= r;
		irqLevel <= l;
		serReadReq <= s;
		// The image is shown whole: its protection byte was written last.
		protByte <= p;
	endtask : side
endmodule : cdrf_core_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench of the CPU register set.
// Assumes: Core side comes from cdrf_core_model.
// Notes: The wait count is shortened to keep the run brief.
`timescale 1ns/1ps
`include "cdrf_cfg.svh"
module testbench
	import cdrf_pkg::*;
;
	localparam int WAIT = 8;
	localparam logic [7:0] CORN_A [3] = '{8'h0F, 8'h80, 8'h7F};
	localparam logic [7:0] CORN_B [3] = '{8'h01, 8'h80, 8'h01};
	localparam logic [15:0] EDGES [6] = '{16'h0000, `CDRF_IO_TOP, 16'h0080, 16'h7FFF,
		`CDRF_PROG_BASE, `CDRF_PROT_ADDR};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, ldEn, ptrStep, aluGo, aluByte, irqReq, serReadReq, stopWake;
	logic irqAccept, serReadGrant, cpuRun;
	cdrf_ldsel_t ldSel;
	cdrf_aluop_t aluOp;
	cdrf_region_t memRegion;
	logic [15:0] ldData, memAddr, bankBase, program_status_word;
	logic [15:0] instruction_pointer, accumulator, temp_operand;
	logic [15:0] index_register, extra_pointer, stack_top_pointer;
	logic [1:0] irqLevel;
	logic [7:0] protByte;
	logic [95:0] allRegs;
	logic [15:0] rnd = 16'h0008;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	assign allRegs = {stack_top_pointer, extra_pointer, index_register, temp_operand,
		accumulator, instruction_pointer};
	always #4 clk = ~clk;
	cdrf_regs #(.OSC_WAIT_CYCLES(WAIT), .PROTECTED_PART(1'b1)) uut (.clk, .srst,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .ldEn, .ldSel, .ldData, .ptrStep, .aluGo, .aluOp, .aluByte, .memAddr,
		.instruction_pointer, .accumulator, .temp_operand, .index_register,
		.extra_pointer, .stack_top_pointer, .program_status_word, .bankBase, .memRegion,
		.irqReq, .irqLevel, .irqAccept, .serReadReq, .protByte, .serReadGrant,
		.stopWake, .cpuRun);
	cdrf_core_model core (.clk, .ldEn, .ldSel, .ldData, .ptrStep, .aluGo, .aluOp,
		.aluByte, .stopWake, .memAddr, .irqReq, .irqLevel, .serReadReq, .protByte);
	// ====================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// Returns {flags, sum} of a byte add, flags in their condition code positions.
	function automatic logic [15:0] add8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [7:0] f;
		s = {1'b0, a} + {1'b0, b};
		f = 8'h00;
		f[`CDRF_CC_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
		f[`CDRF_CC_N] = s[7];
		f[`CDRF_CC_Z] = s[7:0] == 8'h00;
		f[`CDRF_CC_V] = (a[7] == b[7]) && (s[7] != a[7]);
		f[`CDRF_CC_C] = s[8];
		return {f, s[7:0]};
	endfunction : add8
	function automatic cdrf_region_t region(input logic [15:0] x);
		return (x <= `CDRF_IO_TOP) ? CDRF_RG_IO : (x >= `CDRF_PROG_BASE) ? CDRF_RG_PROG :
			CDRF_RG_DATA;
	endfunction : region
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkb(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask : chkb
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h3;
		@(posedge clk);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic alu_case(input cdrf_aluop_t o, input logic by, input logic [15:0] a,
		input logic [15:0] t, input logic [15:0] ea, input logic [7:0] ef, input logic [7:0] m);
		core.load(CDRF_LD_ACC, a);
		core.load(CDRF_LD_TMP, t);
		core.alu(o, by);
		#1;
		chk("alu acc", {16'h0, ea}, {16'h0, accumulator});
		chk("alu flags", {24'h0, ef & m}, {24'h0, program_status_word[7:0] & m});
	endtask : alu_case
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	// A hung handshake would stall the run forever, so a cycle ceiling ends it.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	// ====================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic [15:0] a;
		logic [15:0] e;
		logic [7:0] b;
		logic [4:0] rp;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		core.pulse(1'b0);
		repeat (WAIT - 4) @(posedge clk);
		#1;
		chkb("cpuRun", 1'b0, cpuRun);
		chk("ip", 32'h0, {16'h0, instruction_pointer});
		repeat (4) @(posedge clk);
		#1;
		chkb("cpuRun", 1'b1, cpuRun);
		core.pulse(1'b0);
		#1;
		chk("ip", 32'h1, {16'h0, instruction_pointer});
		core.pulse(1'b1);
		#1;
		chkb("cpuRun", 1'b0, cpuRun);
		wb(1'b0, `CDRF_OFS_PSW, 32'h0, q);
		chk("psw", {16'h0, `CDRF_RP_RST, `CDRF_CCR_RST}, q);
		wb(1'b1, `CDRF_OFS_BANK, 32'hFFFF, q);
		wb(1'b0, `CDRF_OFS_BANK, 32'h0, q);
		chk("bank", {16'h0, `CDRF_BANK_BASE}, q);
		wb(1'b0, 6'h3C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			wb(1'b1, 6'(i * 4), {~rnd, rnd}, q);
			wb(1'b0, 6'(i * 4), 32'h0, q);
			chk("reg", {16'h0, rnd}, q);
			chk("port", {16'h0, rnd}, {16'h0, allRegs[i * 16 +: 16]});
		end
		wb(1'b0, `CDRF_OFS_STAT, 32'h0, q);
		chk("status", 32'h1, q);
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			a = rnd;
			rnd = lfsr(rnd);
			b = rnd[7:0];
			if (i < 3) begin
				a[7:0] = CORN_A[i];
				b = CORN_B[i];
			end
			e = add8(a[7:0], b);
			alu_case(CDRF_OP_ADD, 1'b1, a, {rnd[15:8], b}, {a[15:8], e[7:0]}, e[15:8], 8'h8F);
		end
		alu_case(CDRF_OP_ADD, 1'b0, 16'h8000, 16'h8000, 16'h0000, 8'h07, 8'h8F);
		alu_case(CDRF_OP_SUB, 1'b1, 16'h0010, 16'h0020, 16'h00F0, 8'h09, 8'h8F);
		alu_case(CDRF_OP_SHL, 1'b1, 16'h0081, 16'h0000, 16'h0003, 8'h01, 8'h01);
		alu_case(CDRF_OP_SUB, 1'b1, 16'h0010, 16'h0001, 16'h000F, 8'h80, 8'h8F);
		alu_case(CDRF_OP_ADDC, 1'b1, 16'h00FF, 16'h0001, 16'h0000, 8'h85, 8'h8F);
		alu_case(CDRF_OP_ADDC, 1'b1, 16'h0010, 16'h0020, 16'h0031, 8'h00, 8'h8F);
		alu_case(CDRF_OP_SHR, 1'b0, 16'h8001, 16'h0000, 16'h4000, 8'h01, 8'h01);
		alu_case(CDRF_OP_SUBC, 1'b1, 16'h0005, 16'h0003, 16'h0001, 8'h00, 8'h8F);
		alu_case(CDRF_OP_AND, 1'b1, 16'h00F0, 16'h000F, 16'h0000, 8'h04, 8'h0F);
		alu_case(CDRF_OP_OR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 8'h08, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			rp = (i == 0) ? 5'h1F : rnd[4:0];
			core.load(CDRF_LD_PSW, {3'h0, rp, 8'h60});
			#1;
			chk("base", {16'h0, `CDRF_BANK_BASE + {8'h0, rp, 3'h0}}, {16'h0, bankBase});
			wb(1'b0, `CDRF_OFS_PSW, 32'h0, q);
			chk("psw", {16'h0, 3'h0, rp, 8'h60}, q);
		end
		for (int k = 0; k < 32; k++) begin
			core.load(CDRF_LD_PSW, {9'h0, k[4], k[3:2], 4'h0});
			core.side(16'h0000, 1'b1, k[1:0], 1'b0, 8'hFF);
			#1;
			chkb("irq", k[4] && (k[1:0] < k[3:2]), irqAccept);
		end
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			a = (i < 6) ? EDGES[i] : rnd;
			b = i[0] ? `CDRF_PROT_CODE : (rnd[7:0] | 8'h01);
			core.side(a, 1'b0, 2'h0, i[1], b);
			@(posedge clk);
			#1;
			chk("region", {30'h0, region(a)}, {30'h0, memRegion});
			chkb("grant", i[1] && !i[0], serReadGrant);
		end
		end_sim();
	end
endmodule : testbench

// >>> hw/cdrf_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the CPU register set.
// Assumes: 32-bit classic Wishbone, byte addresses, one aligned word per register.
// Notes: Definitions only.
`ifndef CDRF_CFG_SVH
`define CDRF_CFG_SVH
// ==========================================================================
// Register offsets (byte addresses)
`define CDRF_OFS_IPTR 6'h00
`define CDRF_OFS_ACC 6'h04
`define CDRF_OFS_TMP 6'h08
`define CDRF_OFS_IDX 6'h0C
`define CDRF_OFS_XPTR 6'h10
`define CDRF_OFS_STK 6'h14
`define CDRF_OFS_PSW 6'h18
`define CDRF_OFS_BANK 6'h1C
`define CDRF_OFS_STAT 6'h20
`define CDRF_OFS_REGION 6'h24
// ==========================================================================
// Condition code byte fields
`define CDRF_CC_H 7
`define CDRF_CC_I 6
`define CDRF_CC_IL_HI 5
`define CDRF_CC_IL_LO 4
`define CDRF_CC_N 3
`define CDRF_CC_Z 2
`define CDRF_CC_V 1
`define CDRF_CC_C 0
`define CDRF_CCR_RST 8'h30
`define CDRF_RP_RST 8'h00
`define CDRF_IL_NONE 2'h3
// ==========================================================================
// Memory map
`define CDRF_BANK_BASE 16'h0100
`define CDRF_IO_TOP 16'h007F
`define CDRF_PROG_BASE 16'h8000
`define CDRF_PROT_ADDR 16'hFFFC
`define CDRF_PROT_CODE 8'h00
// ==========================================================================
// Oscillation stabilisation wait
`define CDRF_OSC_WAIT_NS 1000000
`define CDRF_CLK_NS 8
`define CDRF_OSC_WAIT_CYC (`CDRF_OSC_WAIT_NS / `CDRF_CLK_NS)
`endif

// >>> hw/cdrf_pkg.sv
// Purpose: Types shared by the CPU register set.
// Assumes: Constants live in cdrf_cfg.svh.
// Notes: None.
package cdrf_pkg;
	// ==========================================================================
	// Types
	typedef enum logic [2:0] {
		CDRF_LD_IPTR, CDRF_LD_ACC, CDRF_LD_TMP, CDRF_LD_IDX,
		CDRF_LD_XPTR, CDRF_LD_STK, CDRF_LD_PSW
	} cdrf_ldsel_t;
	typedef enum logic [2:0] {
		CDRF_OP_ADD, CDRF_OP_ADDC, CDRF_OP_SUB, CDRF_OP_SUBC,
		CDRF_OP_SHL, CDRF_OP_SHR, CDRF_OP_AND, CDRF_OP_OR
	} cdrf_aluop_t;
	typedef enum logic [1:0] {
		CDRF_RG_IO, CDRF_RG_DATA, CDRF_RG_PROG
	} cdrf_region_t;
	typedef struct packed {
		logic [15:0] res;
		logic n;
		logic z;
		logic v;
		logic c;
		logic h;
	} cdrf_alures_t;
endpackage : cdrf_pkg

// >>> hw/cdrf_regs.sv
// Purpose: Dedicated CPU registers, status word flags, bank pointer and memory map decode.
// Assumes: Core datapath and Wishbone master share clk and srst.
// Notes: Register access by Wishbone gives the debug view and write path.
// ==========================================================================
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cdrf_cfg.svh"
module cdrf_regs
	import cdrf_pkg::*;
#(
	parameter int OSC_WAIT_CYCLES = `CDRF_OSC_WAIT_CYC,
	parameter bit PROTECTED_PART = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core datapath
	input wire logic ldEn,
	input wire cdrf_ldsel_t ldSel,
	input wire logic [15:0] ldData,
	input wire logic ptrStep,
	input wire logic aluGo,
	input wire cdrf_aluop_t aluOp,
	input wire logic aluByte,
	input wire logic [15:0] memAddr,
	output logic [15:0] instruction_pointer,
	output logic [15:0] accumulator,
	output logic [15:0] temp_operand,
	output logic [15:0] index_register,
	output logic [15:0] extra_pointer,
	output logic [15:0] stack_top_pointer,
	output logic [15:0] program_status_word,
	output logic [15:0] bankBase,
	output cdrf_region_t memRegion,
	// Interrupt request from the controller
	input wire logic irqReq,
	input wire logic [1:0] irqLevel,
	output logic irqAccept,
	// Serial programmer read port and clock wake-up
	input wire logic serReadReq,
	input wire logic [7:0] protByte,
	output logic serReadGrant,
	input wire logic stopWake,
	output logic cpuRun
);
	// ==========================================================================
	// ALU
	function automatic cdrf_alures_t aluCalc(input cdrf_aluop_t op, input logic [15:0] a,
		input logic [15:0] b, input logic cin, input logic bm);
		cdrf_alures_t r;
		logic [16:0] s;
		logic [4:0] lo;
		logic sub;
		logic ci;
		logic am;
		logic bmsb;
		r = '0;
		s = '0;
		sub = (op == CDRF_OP_SUB) || (op == CDRF_OP_SUBC);
		ci = ((op == CDRF_OP_ADDC) || (op == CDRF_OP_SUBC)) ? cin : 1'b0;
		if (bm) begin
			a = {8'h00, a[7:0]};
			b = {8'h00, b[7:0]};
		end
		lo = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci})
			: ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci});
		case (op)
			CDRF_OP_ADD, CDRF_OP_ADDC: s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
			CDRF_OP_SUB, CDRF_OP_SUBC: s = {1'b0, a} - {1'b0, b} - {16'h0000, ci};
			CDRF_OP_SHL: s = {1'b0, a[14:0], cin};
			CDRF_OP_SHR: s = bm ? {1'b0, 8'h00, cin, a[7:1]} : {1'b0, cin, a[15:1]};
			CDRF_OP_AND: s = {1'b0, a & b};
			CDRF_OP_OR: s = {1'b0, a | b};
			default: s = '0;
		endcase
		r.res = bm ? {8'h00, s[7:0]} : s[15:0];
		am = bm ? a[7] : a[15];
		bmsb = bm ? b[7] : b[15];
		r.n = bm ? s[7] : s[15];
		r.z = (r.res == 16'h0000);
		r.h = lo[4];
		case (op)
			CDRF_OP_SHL: r.c = bm ? a[7] : a[15];
			CDRF_OP_SHR: r.c = a[0];
			CDRF_OP_AND, CDRF_OP_OR: r.c = cin;
			default: r.c = bm ? (s[8] ^ a[8] ^ b[8]) : s[16];
		endcase
		if (op == CDRF_OP_AND || op == CDRF_OP_OR || op == CDRF_OP_SHL || op == CDRF_OP_SHR) begin
			r.v = 1'b0;
		end else begin
			r.v = sub ? ((am != bmsb) && (r.n != am)) : ((am == bmsb) && (r.n != am));
		end
		return r;
	endfunction : aluCalc

	function automatic cdrf_region_t regionOf(input logic [15:0] addr);
		if (addr <= `CDRF_IO_TOP) begin
			return CDRF_RG_IO;
		end
		return (addr < `CDRF_PROG_BASE) ? CDRF_RG_DATA : CDRF_RG_PROG;
	endfunction : regionOf

	// ==========================================================================
	// Dedicated registers
	logic [15:0] next_ip, next_acc, next_tmp, next_idx, next_xp, next_stk;
	logic [7:0] bankPtr, condCode, next_bankPtr, next_condCode;
	logic [31:0] oscCnt, next_oscCnt;
	logic wbWr;
	cdrf_alures_t alu;

	// A bus write lands at the edge where the master sees ack, while its data still stands.
	assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign alu = aluCalc(aluOp, accumulator, temp_operand, condCode[`CDRF_CC_C], aluByte);

	function automatic logic [15:0] busMerge(input logic [15:0] cur, input logic [31:0] d,
		input logic [3:0] sel);
		return {sel[1] ? d[15:8] : cur[15:8], sel[0] ? d[7:0] : cur[7:0]};
	endfunction : busMerge

	// Core loads take priority over a bus write in the same cycle; the debugger is
	// expected to write only while the core is idle.
	always_comb begin
		next_ip = instruction_pointer;
		next_acc = accumulator;
		next_tmp = temp_operand;
		next_idx = index_register;
		next_xp = extra_pointer;
		next_stk = stack_top_pointer;
		next_bankPtr = bankPtr;
		next_condCode = condCode;
		if (wbWr) begin
			case (wb_adr_i)
				`CDRF_OFS_IPTR: next_ip = busMerge(instruction_pointer, wb_dat_i, wb_sel_i);
				`CDRF_OFS_ACC: next_acc = busMerge(accumulator, wb_dat_i, wb_sel_i);
				`CDRF_OFS_TMP: next_tmp = busMerge(temp_operand, wb_dat_i, wb_sel_i);
				`CDRF_OFS_IDX: next_idx = busMerge(index_register, wb_dat_i, wb_sel_i);
				`CDRF_OFS_XPTR: next_xp = busMerge(extra_pointer, wb_dat_i, wb_sel_i);
				`CDRF_OFS_STK: next_stk = busMerge(stack_top_pointer, wb_dat_i, wb_sel_i);
				`CDRF_OFS_PSW: {next_bankPtr, next_condCode} =
					busMerge(program_status_word, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
		if (ptrStep && cpuRun) begin
			next_ip = instruction_pointer + 16'h0001;
		end
		if (ldEn) begin
			case (ldSel)
				CDRF_LD_IPTR: next_ip = ldData;
				CDRF_LD_ACC: next_acc = ldData;
				CDRF_LD_TMP: next_tmp = ldData;
				CDRF_LD_IDX: next_idx = ldData;
				CDRF_LD_XPTR: next_xp = ldData;
				CDRF_LD_STK: next_stk = ldData;
				CDRF_LD_PSW: {next_bankPtr, next_condCode} = ldData;
				default: ;
			endcase
		end
		if (aluGo) begin
			// Byte operations leave the accumulator's upper byte untouched.
			next_acc = aluByte ? {accumulator[15:8], alu.res[7:0]} : alu.res;
			next_condCode[`CDRF_CC_H] = alu.h;
			next_condCode[`CDRF_CC_N] = alu.n;
			next_condCode[`CDRF_CC_Z] = alu.z;
			next_condCode[`CDRF_CC_V] = alu.v;
			next_condCode[`CDRF_CC_C] = alu.c;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			instruction_pointer <= 16'h0000;
			accumulator <= 16'h0000;
			temp_operand <= 16'h0000;
			index_register <= 16'h0000;
			extra_pointer <= 16'h0000;
			stack_top_pointer <= 16'h0000;
			bankPtr <= `CDRF_RP_RST;
			condCode <= `CDRF_CCR_RST;
		end else begin
			instruction_pointer <= next_ip;
			accumulator <= next_acc;
			temp_operand <= next_tmp;
			index_register <= next_idx;
			extra_pointer <= next_xp;
			stack_top_pointer <= next_stk;
			bankPtr <= next_bankPtr;
			condCode <= next_condCode;
		end
	end

	assign program_status_word = {bankPtr, condCode};
	assign bankBase = `CDRF_BANK_BASE + {8'h00, bankPtr[4:0], 3'b000};

	// ==========================================================================
	// Interrupt gating; a lower request code is a higher priority.
	assign irqAccept = irqReq && condCode[`CDRF_CC_I]
		&& (irqLevel < condCode[`CDRF_CC_IL_HI:`CDRF_CC_IL_LO]);

	// ==========================================================================
	// Memory map and read protection
	always_ff @(posedge clk) begin
		if (srst) begin
			memRegion <= CDRF_RG_IO;
		end else begin
			memRegion <= regionOf(memAddr);
		end
	end

	// Once the code is stored nothing, including verify, can read it back.
	assign serReadGrant = serReadReq
		&& !(PROTECTED_PART && (protByte == `CDRF_PROT_CODE));

	// ==========================================================================
	// Oscillation stabilisation wait. The core holds until the count drains, even
	// with an external clock, since nothing tells us that clock is already steady.
	always_comb begin
		next_oscCnt = oscCnt;
		if (stopWake) begin
			next_oscCnt = OSC_WAIT_CYCLES;
		end else if (oscCnt != 32'h0000_0000) begin
			next_oscCnt = oscCnt - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			oscCnt <= OSC_WAIT_CYCLES;
		end else begin
			oscCnt <= next_oscCnt;
		end
	end

	assign cpuRun = (oscCnt == 32'h0000_0000);

	// ==========================================================================
	// Wishbone slave: answer one cycle after the request, unmapped reads give zero.
	logic [31:0] next_rdat;
	logic next_ack;

	always_comb begin
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		case (wb_adr_i)
			`CDRF_OFS_IPTR: next_rdat = {16'h0000, instruction_pointer};
			`CDRF_OFS_ACC: next_rdat = {16'h0000, accumulator};
			`CDRF_OFS_TMP: next_rdat = {16'h0000, temp_operand};
			`CDRF_OFS_IDX: next_rdat = {16'h0000, index_register};
			`CDRF_OFS_XPTR: next_rdat = {16'h0000, extra_pointer};
			`CDRF_OFS_STK: next_rdat = {16'h0000, stack_top_pointer};
			`CDRF_OFS_PSW: next_rdat = {16'h0000, program_status_word};
			`CDRF_OFS_BANK: next_rdat = {16'h0000, bankBase};
			`CDRF_OFS_STAT: next_rdat = {30'h0000_0000, serReadGrant, cpuRun};
			`CDRF_OFS_REGION: next_rdat = {30'h0000_0000, memRegion};
			default: next_rdat = 32'h0000_0000;
		endcase
		if (!next_ack) begin
			next_rdat = wb_dat_o;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_rdat;
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_IEN_RESET: assert property ($fell(srst) |-> !condCode[`CDRF_CC_I])
		else $error("Interrupt enable not clear after reset.");
	AST_IRQ_GATE: assert property (irqAccept |-> condCode[`CDRF_CC_I]
		&& irqLevel < condCode[5:4])
		else $error("Interrupt accepted against level or enable.");
	AST_IL_NONE: assert property (condCode[5:4] == `CDRF_IL_NONE && irqLevel == 2'h3
		|-> !irqAccept)
		else $error("Level three accepted an interrupt.");
	AST_ZERO: assert property (aluGo && aluByte |=> condCode[`CDRF_CC_Z]
		== (accumulator[7:0] == 8'h00))
		else $error("Zero flag disagrees with result.");
	AST_NEG: assert property (aluGo && aluByte |=> condCode[`CDRF_CC_N] == accumulator[7])
		else $error("Negative flag disagrees with result.");
	AST_CARRY: assert property (aluGo && aluByte && aluOp == CDRF_OP_ADD |=>
		condCode[`CDRF_CC_C] == (({1'b0, $past(accumulator[7:0])}
		+ {1'b0, $past(temp_operand[7:0])}) > 9'h0FF))
		else $error("Carry flag wrong after byte add.");
	AST_HALF: assert property (aluGo && aluOp == CDRF_OP_ADD |=>
		condCode[`CDRF_CC_H] == (({1'b0, $past(accumulator[3:0])}
		+ {1'b0, $past(temp_operand[3:0])}) > 5'h0F))
		else $error("Half carry wrong after add.");
	AST_OVF: assert property (aluGo && aluByte && aluOp == CDRF_OP_ADD
		&& accumulator[7] == temp_operand[7] |=> condCode[`CDRF_CC_V]
		== (accumulator[7] != $past(accumulator[7])))
		else $error("Overflow flag wrong after byte add.");
	AST_BANK: assert property (bankBase == 16'h0100 + 16'(bankPtr[4:0]) * 16'h0008)
		else $error("Bank base does not follow bank pointer.");
	AST_PROTECT: assert property (PROTECTED_PART && protByte == 8'h00 |-> !serReadGrant)
		else $error("Protected contents granted to programmer.");
	AST_OSC_WAIT: assert property (stopWake |=> !cpuRun [*2])
		else $error("Core ran without stabilisation wait.");
	AST_STEP_HOLD: assert property (!cpuRun && ptrStep && !ldEn && !wbWr
		|=> $stable(instruction_pointer))
		else $error("Pointer advanced during clock wait.");
	AST_WB_ACK: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle.");
	// The checks below tie each data path result to its rule one edge later.
	AST_BYTE_UPPER: assert property (aluGo && aluByte
		|=> accumulator[15:8] == $past(accumulator[15:8]))
		else $error("Byte operation changed the accumulator upper byte.");
	AST_SHIFT_OUT: assert property (aluGo && aluOp == CDRF_OP_SHR
		|=> condCode[`CDRF_CC_C] == $past(accumulator[0]))
		else $error("Carry does not hold the bit shifted out.");
	AST_ZERO_WORD: assert property (aluGo && !aluByte
		|=> condCode[`CDRF_CC_Z] == (accumulator == 16'h0000))
		else $error("Zero flag disagrees with word result.");
	AST_NEG_WORD: assert property (aluGo && !aluByte
		|=> condCode[`CDRF_CC_N] == accumulator[15])
		else $error("Negative flag disagrees with word result.");
	AST_STEP: assert property (ptrStep && cpuRun && !ldEn
		|=> instruction_pointer == $past(instruction_pointer) + 16'h0001)
		else $error("Pointer did not advance on a step.");
	AST_REGION_IO: assert property (memAddr <= `CDRF_IO_TOP
		|=> memRegion == CDRF_RG_IO)
		else $error("Low address not classed as input or output.");
	AST_REGION_PROG: assert property (memAddr >= `CDRF_PROG_BASE
		|=> memRegion == CDRF_RG_PROG)
		else $error("High address not classed as program.");
	AST_WAIT_LOAD: assert property (stopWake |=> oscCnt == OSC_WAIT_CYCLES)
		else $error("Wake-up did not restart the stabilisation wait.");
	AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Request not answered in the next cycle.");

	COV_IRQ: cover property (irqAccept);
	COV_REFUSE: cover property (serReadReq && !serReadGrant);
	COV_CARRY: cover property (aluGo ##1 condCode[`CDRF_CC_C]);
	COV_WAKE: cover property (stopWake ##[1:8] !cpuRun);
	COV_CARRY_IN: cover property (aluGo && aluOp == CDRF_OP_ADDC && condCode[`CDRF_CC_C]);
endmodule : cdrf_regs
